/* File: pkg/spsps_pkg.sv */
// Package: register map, field positions and reset values of the SPI slave port status block
package spsps_pkg;
	// Register indices; the APB byte address is four times the index
	localparam logic [15:0] IDX_FLASH_PROTECT = 16'h00b2;
	localparam logic [15:0] IDX_HOST_CMD = 16'h00fd;
	localparam logic [15:0] IDX_PREV_STATUS = 16'h2708;
	localparam logic [15:0] IDX_PORT_CTRL = 16'h270c;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h2800;
	localparam logic [15:0] IDX_IRQ_ENABLE = 16'h2801;
	localparam logic [15:0] IDX_IRQ_CLEAR = 16'h2802;
	localparam logic [15:0] IDX_PROTECT_CFG = 16'h2803;
	// Field positions
	localparam int FLASH_PROTECT_POS = 6;
	localparam int PORT_EN_POS = 4;
	localparam int WR_RESTRICT_POS = 3;
	localparam int ST_RDY_ERR = 7;
	localparam int ST_RD_PAR = 6;
	localparam int ST_WR_PAR = 5;
	localparam int ST_CNT_HI = 4;
	localparam int ST_CNT_LO = 2;
	localparam int ST_FLASH_MODE = 1;
	localparam int ST_FLASH_RDY = 0;
	// Reset values
	localparam logic FLASH_PROTECT_RST = 1'h0;
	localparam logic PORT_EN_RST = 1'h1;
	localparam logic WR_RESTRICT_RST = 1'h0;
	localparam logic [7:0] PREV_STATUS_RST = 8'h00;
	localparam logic [7:0] HOST_CMD_RST = 8'h00;
	localparam logic [15:0] SAFE_BASE_RST = 16'h0000;
	localparam logic [15:0] CODE_START_RST = 16'hffff;
	localparam logic [2:0] SHORT_CNT = 3'h7;
	localparam int SAFE_LEN = 16;
	// Interrupt events
	localparam int IRQ_CMD = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_BLOCKED = 2;
	localparam int IRQ_W = 3;
	// Command encodings
	localparam logic [7:0] CMD_RD = 8'h01;
	localparam logic [7:0] CMD_WR = 8'h02;
	localparam logic [7:0] CMD_FL_RD = 8'h03;
	localparam logic [7:0] CMD_FL_WR = 8'h04;
	localparam logic [7:0] CMD_FL_ERASE = 8'h05;
endpackage : spsps_pkg

/* File: hdl/spsps_shift.sv */
// Byte shifter on the sampled SPI pins, SPI mode 0, MSB first
`timescale 1ns/100ps
module spsps_shift (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Synchronised pins
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	// Byte to send
	input wire logic [7:0] i_tx,
	// Events
	output logic o_start,
	output logic o_byte,
	output logic [7:0] o_rx,
	output logic o_end,
	output logic o_miso
);
	logic sck_d_r;
	logic cs_d_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	wire rise = i_sck && !sck_d_r && !i_cs_n;
	wire fall = !i_sck && sck_d_r && !i_cs_n;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			sck_d_r <= i_sck;
			cs_d_r <= i_cs_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			o_byte <= 1'b0;
			o_rx <= 8'h00;
		end else begin
			o_byte <= 1'b0;
			if (i_cs_n) begin
				bit_r <= 3'h0;
			end else if (rise) begin
				sh_r <= {sh_r[6:0], i_mosi};
				bit_r <= bit_r + 3'h1;
				if (bit_r == 3'h7) begin
					o_byte <= 1'b1;
					o_rx <= {sh_r[6:0], i_mosi};
				end
			end
		end
	end

	// Transmit shifter loads a new byte at each byte boundary
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_r <= 8'h00;
		end else if (i_cs_n || (fall && bit_r == 3'h0)) begin
			tx_r <= i_tx;
		end else if (fall) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_start <= 1'b0;
			o_end <= 1'b0;
		end else begin
			o_start <= cs_d_r && !i_cs_n;
			o_end <= !cs_d_r && i_cs_n;
		end
	end

	assign o_miso = tx_r[7];
endmodule : spsps_shift

/* File: hdl/spsps_top.sv */
// SPI slave port: command capture, write restriction, transfer status, flash protection
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module spsps_top #(
	parameter int ADDR_W = 16,
	parameter int PAGE_W = 10
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [17:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Shared segment/IO pins
	input wire logic i_seg_sck,
	input wire logic i_seg_cs_n,
	input wire logic i_seg_mosi,
	input wire logic [3:0] i_segment_pin_select,
	output logic o_seg_miso,
	output logic o_seg_miso_oe_n,
	// Device status
	input wire logic i_test_pin,
	input wire logic i_mem_ready,
	input wire logic i_flash_ready,
	// Memory access request
	output logic o_mem_we,
	output logic o_mem_flash,
	output logic o_mem_erase,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata,
	// Interrupt
	output logic o_irq
);
	typedef enum {SPSPS_CMD, SPSPS_ADH, SPSPS_ADL, SPSPS_DATA} spsps_state_t;
	spsps_state_t st_r;
	logic [1:0] sck_s_r;
	logic [1:0] cs_s_r;
	logic [1:0] mosi_s_r;
	logic [1:0] test_s_r;
	logic port_en_r;
	logic wr_restrict_r;
	logic flash_protect_r;
	logic [15:0] safe_base_r;
	logic [15:0] code_start_r;
	logic [7:0] host_cmd_r;
	logic [7:0] status_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0] nbytes_r;
	logic rd_par_r;
	logic wr_par_r;
	logic rdy_err_r;
	logic [2:0] irq_st_r;
	logic [2:0] irq_en_r;
	logic [7:0] tx_r;
	logic [2:0] irq_set;
	logic start;
	logic byte_v;
	logic [7:0] rx;
	logic xend;
	logic miso;
	logic link_ok;
	logic link_cs_n;

	// Two-flop pin synchronisers; edge detection lives inside the shifter
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sck_s_r <= 2'h0;
			cs_s_r <= 2'h3;
			mosi_s_r <= 2'h0;
			test_s_r <= 2'h0;
		end else begin
			sck_s_r <= {sck_s_r[0], i_seg_sck};
			cs_s_r <= {cs_s_r[0], i_seg_cs_n};
			mosi_s_r <= {mosi_s_r[0], i_seg_mosi};
			test_s_r <= {test_s_r[0], i_test_pin};
		end
	end

	assign link_ok = port_en_r && (i_segment_pin_select == 4'h0);
	assign link_cs_n = cs_s_r[1] || !link_ok;

	spsps_shift u_shift (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_sck(sck_s_r[1]),
		.i_cs_n(link_cs_n),
		.i_mosi(mosi_s_r[1]),
		.i_tx(tx_r),
		.o_start(start),
		.o_byte(byte_v),
		.o_rx(rx),
		.o_end(xend),
		.o_miso(miso)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_seg_miso <= 1'b0;
			o_seg_miso_oe_n <= 1'b1;
		end else begin
			o_seg_miso <= miso;
			o_seg_miso_oe_n <= !(link_ok && !cs_s_r[1]);
		end
	end

	// Access checks
	wire is_wr = (host_cmd_r == spsps_pkg::CMD_WR) || (host_cmd_r == spsps_pkg::CMD_FL_WR);
	wire is_rd = (host_cmd_r == spsps_pkg::CMD_RD) || (host_cmd_r == spsps_pkg::CMD_FL_RD);
	wire in_safe = (addr_r >= safe_base_r) && (addr_r < safe_base_r + 16'(spsps_pkg::SAFE_LEN));
	wire wr_ok = !wr_restrict_r || (host_cmd_r == spsps_pkg::CMD_WR && in_safe);
	wire fl_rd_ok = !flash_protect_r;
	wire [ADDR_W-1:0] ea = addr_r | ADDR_W'(rx);
	wire er_ok = !flash_protect_r ||
		(ea[ADDR_W-1:PAGE_W] != '0 && ea < code_start_r);
	wire fl_mode = test_s_r[1] && (host_cmd_r == spsps_pkg::CMD_FL_RD ||
		host_cmd_r == spsps_pkg::CMD_FL_WR || host_cmd_r == spsps_pkg::CMD_FL_ERASE);
	wire ready = (host_cmd_r == spsps_pkg::CMD_FL_WR) ? i_flash_ready : i_mem_ready;

	// Transaction sequencer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= SPSPS_CMD;
			host_cmd_r <= spsps_pkg::HOST_CMD_RST;
			addr_r <= '0;
			nbytes_r <= 8'h00;
			rd_par_r <= 1'b0;
			wr_par_r <= 1'b0;
			rdy_err_r <= 1'b0;
			tx_r <= 8'h00;
			o_mem_we <= 1'b0;
			o_mem_flash <= 1'b0;
			o_mem_erase <= 1'b0;
			o_mem_addr <= '0;
			o_mem_wdata <= 8'h00;
		end else begin
			o_mem_we <= 1'b0;
			o_mem_erase <= 1'b0;
			// Between frames the return shifter is primed with the latest status
			if (link_cs_n) begin
				tx_r <= status_r;
			end else if (start) begin
				st_r <= SPSPS_CMD;
				nbytes_r <= 8'h00;
				rd_par_r <= 1'b0;
				wr_par_r <= 1'b0;
				rdy_err_r <= 1'b0;
				tx_r <= status_r;
			end else if (byte_v) begin
				wr_par_r <= wr_par_r ^ (^rx);
				case (st_r)
					SPSPS_CMD: begin
						host_cmd_r <= rx;
						st_r <= SPSPS_ADH;
					end
					SPSPS_ADH: begin
						addr_r <= ADDR_W'({rx, 8'h00});
						st_r <= SPSPS_ADL;
					end
					SPSPS_ADL: begin
						addr_r <= addr_r | ADDR_W'(rx);
						st_r <= SPSPS_DATA;
						if (host_cmd_r == spsps_pkg::CMD_FL_ERASE) begin
							o_mem_erase <= er_ok;
							o_mem_flash <= 1'b1;
							o_mem_addr <= addr_r | ADDR_W'(rx);
						end
						if (is_rd) begin
							tx_r <= (host_cmd_r == spsps_pkg::CMD_FL_RD && !fl_rd_ok) ?
								8'h00 : i_mem_rdata;
						end
					end
					SPSPS_DATA: begin
						nbytes_r <= nbytes_r + 8'h01;
						if (!ready && (is_rd || is_wr)) begin
							rdy_err_r <= 1'b1;
						end
						if (is_rd) begin
							rd_par_r <= rd_par_r ^ (^tx_r);
							tx_r <= (host_cmd_r == spsps_pkg::CMD_FL_RD && !fl_rd_ok) ?
								8'h00 : i_mem_rdata;
						end
						if (is_wr && wr_ok && ready) begin
							o_mem_we <= 1'b1;
							o_mem_flash <= host_cmd_r == spsps_pkg::CMD_FL_WR;
							o_mem_wdata <= rx;
						end
						o_mem_addr <= addr_r;
						addr_r <= addr_r + ADDR_W'(1);
					end
					default: st_r <= SPSPS_CMD;
				endcase
			end
		end
	end

	// Status snapshot at the end of each transaction
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			status_r <= spsps_pkg::PREV_STATUS_RST;
		end else if (xend) begin
			status_r[spsps_pkg::ST_RDY_ERR] <= rdy_err_r;
			status_r[spsps_pkg::ST_RD_PAR] <= rd_par_r;
			status_r[spsps_pkg::ST_WR_PAR] <= wr_par_r;
			status_r[spsps_pkg::ST_CNT_HI:spsps_pkg::ST_CNT_LO] <=
				(st_r != SPSPS_DATA || nbytes_r == 8'h00) ? spsps_pkg::SHORT_CNT :
				nbytes_r[2:0];
			status_r[spsps_pkg::ST_FLASH_MODE] <= fl_mode;
			status_r[spsps_pkg::ST_FLASH_RDY] <= fl_mode && i_flash_ready;
		end else if (!test_s_r[1]) begin
			status_r[spsps_pkg::ST_FLASH_MODE] <= 1'b0;
			status_r[spsps_pkg::ST_FLASH_RDY] <= 1'b0;
		end
	end

	// APB slave, single wait-free access
	wire [15:0] idx = i_paddr[17:2];
	wire acc = i_psel && i_penable;
	wire wr = acc && i_pwrite;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			port_en_r <= spsps_pkg::PORT_EN_RST;
			wr_restrict_r <= spsps_pkg::WR_RESTRICT_RST;
			flash_protect_r <= spsps_pkg::FLASH_PROTECT_RST;
			safe_base_r <= spsps_pkg::SAFE_BASE_RST;
			code_start_r <= spsps_pkg::CODE_START_RST;
			irq_en_r <= 3'h0;
		end else if (wr) begin
			case (idx)
				spsps_pkg::IDX_PORT_CTRL: begin
					port_en_r <= i_pwdata[spsps_pkg::PORT_EN_POS];
					wr_restrict_r <= i_pwdata[spsps_pkg::WR_RESTRICT_POS];
				end
				spsps_pkg::IDX_FLASH_PROTECT: flash_protect_r <= i_pwdata[spsps_pkg::FLASH_PROTECT_POS];
				spsps_pkg::IDX_PROTECT_CFG: begin
					safe_base_r <= i_pwdata[15:0];
					code_start_r <= i_pwdata[31:16];
				end
				spsps_pkg::IDX_IRQ_ENABLE: irq_en_r <= i_pwdata[spsps_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Interrupt status: set wins over clear
	assign irq_set = {(o_mem_erase == 1'b0) && byte_v && st_r == SPSPS_DATA && is_wr && !wr_ok,
		xend, byte_v && st_r == SPSPS_CMD};
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_st_r <= 3'h0;
			o_irq <= 1'b0;
		end else begin
			irq_st_r <= (irq_st_r & ~((wr && idx == spsps_pkg::IDX_IRQ_CLEAR) ?
				i_pwdata[2:0] : 3'h0)) | irq_set;
			o_irq <= |(irq_st_r & irq_en_r);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0;
			if (i_psel && !i_penable && !i_pwrite) begin
				case (i_paddr[17:2])
					spsps_pkg::IDX_FLASH_PROTECT:
						o_prdata <= 32'(flash_protect_r) << spsps_pkg::FLASH_PROTECT_POS;
					spsps_pkg::IDX_HOST_CMD: o_prdata <= {24'h0, host_cmd_r};
					spsps_pkg::IDX_PREV_STATUS: o_prdata <= {24'h0, status_r};
					spsps_pkg::IDX_PORT_CTRL: o_prdata <= {27'h0, port_en_r, wr_restrict_r, 3'h0};
					spsps_pkg::IDX_IRQ_STATUS: o_prdata <= {29'h0, irq_st_r};
					spsps_pkg::IDX_IRQ_ENABLE: o_prdata <= {29'h0, irq_en_r};
					spsps_pkg::IDX_PROTECT_CFG: o_prdata <= {code_start_r, safe_base_r};
					default: o_pslverr <= 1'b1;
				endcase
			end else if (i_psel && !i_penable) begin
				o_pslverr <= !(i_paddr[17:2] inside {spsps_pkg::IDX_FLASH_PROTECT,
					spsps_pkg::IDX_PORT_CTRL, spsps_pkg::IDX_IRQ_ENABLE,
					spsps_pkg::IDX_IRQ_CLEAR, spsps_pkg::IDX_PROTECT_CFG});
			end
		end
	end

	// Checks
	AST_CMD_CAPTURE: assert property (@(posedge i_clk) disable iff (i_rst)
		byte_v && st_r == SPSPS_CMD |=> host_cmd_r == $past(rx))
		else $error("command byte not captured");
	AST_RESTRICT: assert property (@(posedge i_clk) disable iff (i_rst)
		o_mem_we && !o_mem_flash |-> !wr_restrict_r || $past(in_safe))
		else $error("restricted write passed");
	AST_STATUS_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(xend) && test_s_r[1] && $past(test_s_r[1]) |-> $stable(status_r))
		else $error("status changed mid transaction");
	AST_SHORT_CNT: assert property (@(posedge i_clk) disable iff (i_rst)
		xend && (st_r != SPSPS_DATA || nbytes_r == 8'h00)
		|=> status_r[spsps_pkg::ST_CNT_HI:spsps_pkg::ST_CNT_LO] == spsps_pkg::SHORT_CNT)
		else $error("short instruction count wrong");
	AST_FLASH_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
		!test_s_r[1] |=> !status_r[1])
		else $error("flash mode set with test low");
	AST_FL_READ: assert property (@(posedge i_clk) disable iff (i_rst)
		flash_protect_r && host_cmd_r == spsps_pkg::CMD_FL_RD && byte_v &&
		(st_r == SPSPS_ADL || st_r == SPSPS_DATA)
		|=> tx_r == 8'h00)
		else $error("protected flash read leaked");
	AST_ERASE: assert property (@(posedge i_clk) disable iff (i_rst)
		o_mem_erase && flash_protect_r |-> o_mem_addr[ADDR_W-1:PAGE_W] != '0)
		else $error("page zero erased while protected");
	AST_PORT_EN: assert property (@(posedge i_clk) disable iff (i_rst)
		!port_en_r ##1 !port_en_r |-> o_seg_miso_oe_n)
		else $error("pin driven with port disabled");
	// A data byte taken in the data phase of a read or write
	sequence spsps_data_byte_s;
		byte_v && st_r == SPSPS_DATA && (is_rd || is_wr);
	endsequence
	AST_RDY_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
		spsps_data_byte_s ##0 !ready |=> rdy_err_r)
		else $error("not ready access not flagged");
	AST_WR_PARITY: assert property (@(posedge i_clk) disable iff (i_rst)
		xend |=> status_r[spsps_pkg::ST_WR_PAR] == $past(wr_par_r))
		else $error("write parity not reported");
	AST_COUNT: assert property (@(posedge i_clk) disable iff (i_rst)
		xend && st_r == SPSPS_DATA && nbytes_r != 8'h00
		|=> status_r[spsps_pkg::ST_CNT_HI:spsps_pkg::ST_CNT_LO] == $past(nbytes_r[2:0]))
		else $error("byte count not reported");
endmodule : spsps_top

/* File: tb/spsps_master.sv */
// SPI bus master model on the shared pins, mode 0, MSB first
`timescale 1ns/100ps
module spsps_master (
	// Serial return line
	input wire logic i_miso,
	// Driven pins
	output logic o_sck,
	output logic o_cs_n,
	output logic o_mosi
);
	logic [7:0] tx_q [16];
	logic [7:0] rx_q [16];
	integer i;
	integer b;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	// One frame of n bytes; link clock 400 ns, still low between frames
	task run(input integer n);
		#37 o_cs_n = 1'b0;
		#200;
		for (i = 0; i < n; i++) begin
			for (b = 7; b >= 0; b--) begin
				o_mosi = tx_q[i][b];
				#200 o_sck = 1'b1;
				rx_q[i][b] = i_miso;
				#200 o_sck = 1'b0;
			end
		end
		#200 o_cs_n = 1'b1;
		// Released data line shows no stale level
		o_mosi = ~o_mosi;
	endtask : run
endmodule : spsps_master

/* File: tb/spsps_top_tb_top.sv */
// Testbench for the SPI slave port status block
`timescale 1ns/100ps
module spsps_top_tb_top;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, sck, cs_n, mosi, miso, oe_n, we, fl, er, irq, e;
	logic test_pin = 1'b0, mem_ready = 1'b1, flip = 1'b0, drove = 1'b0;
	logic [7:0] wdata;
	logic [15:0] maddr;
	integer err_total = 0, n_compared = 0, nwe = 0, ner = 0, n_drv = 0, d0 = 0;
	always #25 clk = ~clk;
	// Undriven return line shows a changing pattern
	wire miso_line = oe_n ? flip : miso;
	always @(posedge clk) begin
		flip <= ~flip;
		if (we === 1'b1) nwe <= nwe + 1;
		if (er === 1'b1) ner <= ner + 1;
		if (oe_n === 1'b0) n_drv <= n_drv + 1;
	end
	spsps_top dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_seg_sck(sck), .i_seg_cs_n(cs_n),
		.i_seg_mosi(mosi), .i_segment_pin_select(4'h0), .o_seg_miso(miso),
		.o_seg_miso_oe_n(oe_n), .i_test_pin(test_pin), .i_mem_ready(mem_ready),
		.i_flash_ready(1'b1), .o_mem_we(we), .o_mem_flash(fl), .o_mem_erase(er),
		.o_mem_addr(maddr), .o_mem_wdata(wdata), .i_mem_rdata(8'h07), .o_irq(irq));
	spsps_master m (.i_miso(miso_line), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task stop_test;
		$display("errors=%0d compared=%0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		integer k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 16) begin
			err_total++;
			stop_test();
		end
	endtask : apb
	// Frame of n bytes, left aligned in b, then status read back
	task spi(input integer n, input logic [47:0] b);
		integer k;
		for (k = 0; k < n; k++) m.tx_q[k] = b[47-8*k -: 8];
		d0 = n_drv;
		m.run(n);
		repeat (8) @(posedge clk);
		drove = (n_drv != d0);
		apb(1'b0, spsps_pkg::IDX_PREV_STATUS, 32'h0);
	endtask : spi
	function automatic logic [31:0] st(input logic rp, input logic [47:0] b, input logic [2:0] c);
		return {24'h0, 1'b0, rp, ^b, c, 2'b00};
	endfunction : st
	task t_reset;
		apb(1'b0, spsps_pkg::IDX_PORT_CTRL, 32'h0);
		chk(q, 32'h10);
		apb(1'b0, spsps_pkg::IDX_FLASH_PROTECT, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, spsps_pkg::IDX_PREV_STATUS, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, spsps_pkg::IDX_PREV_STATUS, 32'hff);
		chk(32'(e), 32'h1);
		apb(1'b0, 16'h0001, 32'h0);
		chk(32'(e), 32'h1);
	endtask : t_reset
	task t_xfer;
		spi(5, 48'h0200103c8000);
		chk(32'(nwe), 32'h2);
		chk(32'(wdata), 32'h80);
		chk(32'(maddr), 32'h11);
		chk(32'(fl), 32'h0);
		chk(q & 32'hfe, st(1'b0, 48'h0200103c8000, 3'h2));
		apb(1'b0, spsps_pkg::IDX_HOST_CMD, 32'h0);
		chk(q, 32'h2);
		apb(1'b1, spsps_pkg::IDX_HOST_CMD, 32'h5);
		chk(32'(e), 32'h1);
		spi(3, 48'h010020000000);
		chk(32'(m.rx_q[0]) & 32'hfe, 32'h28);
		chk(q & 32'hfe, st(1'b0, 48'h010020000000, 3'h7));
		spi(6, 48'h010020000000);
		chk(32'({m.rx_q[3], m.rx_q[5]}), 32'h0707);
		chk(32'(drove), 32'h1);
		chk(q & 32'hfe, st(1'b1, 48'h010020000000, 3'h3));
		mem_ready <= 1'b0;
		spi(4, 48'h010020000000);
		chk(32'(q[7]), 32'h1);
		mem_ready <= 1'b1;
	endtask : t_xfer
	task t_restrict;
		apb(1'b1, spsps_pkg::IDX_IRQ_ENABLE, 32'h4);
		apb(1'b1, spsps_pkg::IDX_PORT_CTRL, 32'h18);
		spi(4, 48'h020100550000);
		chk(32'(nwe), 32'h2);
		chk(32'(irq), 32'h1);
		spi(4, 48'h020005550000);
		chk(32'(nwe), 32'h3);
		apb(1'b1, spsps_pkg::IDX_IRQ_ENABLE, 32'h0);
		apb(1'b0, spsps_pkg::IDX_IRQ_STATUS, 32'h0);
		chk(q & 32'h4, 32'h4);
		chk(32'(irq), 32'h0);
		apb(1'b1, spsps_pkg::IDX_IRQ_CLEAR, 32'h4);
		apb(1'b0, spsps_pkg::IDX_IRQ_STATUS, 32'h0);
		chk(q & 32'h4, 32'h0);
		apb(1'b1, spsps_pkg::IDX_PORT_CTRL, 32'h10);
	endtask : t_restrict
	task t_flash;
		test_pin <= 1'b1;
		apb(1'b1, spsps_pkg::IDX_PROTECT_CFG, 32'h80000000);
		apb(1'b1, spsps_pkg::IDX_FLASH_PROTECT, 32'h40);
		apb(1'b0, spsps_pkg::IDX_FLASH_PROTECT, 32'h0);
		chk(q, 32'h40);
		spi(5, 48'h030000000000);
		chk(32'(m.rx_q[4]), 32'h0);
		chk(q & 32'h3, 32'h3);
		spi(3, 48'h050000000000);
		spi(3, 48'h058400000000);
		chk(32'(ner), 32'h0);
		spi(3, 48'h050400000000);
		chk(32'(ner), 32'h1);
		chk(32'(maddr), 32'h400);
		chk(32'(fl), 32'h1);
		test_pin <= 1'b0;
		spi(5, 48'h030000000000);
		chk(q & 32'h2, 32'h0);
	endtask : t_flash
	task t_off;
		apb(1'b1, spsps_pkg::IDX_PORT_CTRL, 32'h0);
		spi(4, 48'h020010110000);
		chk(32'(nwe), 32'h3);
		chk(32'(drove), 32'h0);
	endtask : t_off
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_xfer();
		t_restrict();
		t_flash();
		t_off();
		stop_test();
	end
endmodule : spsps_top_tb_top
